// file: rtl/adc_global_config_test_regs.v
// global configuration and test register group of an interleaved adc
// assumes a serial port front end on the same clock that issues
// one-cycle write and read strobes and a one-cycle soft reset pulse
//
// Behaviour
// (R1) skew trim code drives linear 256-step core skew
// (R2) skew trim resets to 80h, zero offset
// (R3) phase slip shifts divided clock one cycle
// (R4) host slips by writing bit0 zero then one
// (R5) divisor field: pin, divide one, divide two
// (R6) soft reset keeps divisor and format registers
// (R7) drive field: pin, lvds 2ma, 3ma, lvcmos
// (R8) code field: pin, twos, gray, offset binary
// (R9) loop status bit 6 selects slow range
// (R10) host picks loop range by sample rate
// (R11) rate and loop registers jointly set ddr, range
// (R12) host writes desired xor both read values
// (R13) mode bits 7:6 static or alternate only
// (R14) alternate mode swaps words each clock
// (R15) pattern reaches outputs several cycles later
// (R16) selector picks preset, user or off pattern
// (R17) c2h, c3h form first user word
// (R18) c4h, c5h form second user word
// (R19) soft reset restores other register defaults
// (R20) rate write decoded xor prior two registers
// (R21) pin code 000 follows tri-level pin continuously
`timescale 1ns/1ps
`include "adc_global_defs.vh"

module adc_global_config_test_regs (
  input  wire        clock,                   // 10 mhz block clock
  input  wire        nrst,                    // synchronous reset, low
  input  wire        reg_write,               // write strobe, one cycle
  input  wire        reg_read,                // read strobe, one cycle
  input  wire [12:0] reg_addr,                // register address
  input  wire [7:0]  reg_wdata,               // write data
  input  wire        soft_reset,              // soft reset pulse
  input  wire [1:0]  divisor_select_pin,      // tri-level divisor pin
  input  wire [1:0]  output_drive_select_pin, // tri-level drive pin
  input  wire [1:0]  output_code_select_pin,  // tri-level code pin
  output reg  [7:0]  reg_rdata,               // read data
  output reg         read_valid,              // read data valid pulse
  output reg  [7:0]  skew_trim,               // core skew trim code
  output reg         div_by_two,              // divide by two active
  output reg         divided_phase,           // divided clock phase
  output reg  [1:0]  drive_mode,              // effective output drive
  output reg  [1:0]  code_format,             // effective sample code
  output reg         ddr_enable,              // double data rate
  output reg         loop_slow,               // loop slow range
  output reg         test_active,             // test pattern driven
  output reg  [15:0] test_word                // test pattern word
);

  // register storage
  reg [7:0]  core_skew_trim;         // skew trim code
  reg [7:0]  divided_clock_advance;  // phase slip register
  reg [7:0]  divisor_override;       // divisor override
  reg [7:0]  output_format_override; // drive and code override
  reg [7:0]  output_rate_control;    // last raw rate write
  reg [7:0]  loop_range_state;       // decoded rate setting
  reg [7:0]  pattern_test_control;   // pattern mode and selector
  reg [7:0]  custom_word_one_low;    // first user word, low
  reg [7:0]  custom_word_one_high;   // first user word, high
  reg [7:0]  custom_word_two_low;    // second user word, low
  reg [7:0]  custom_word_two_high;   // second user word, high

  reg        slip_request;           // pending phase slip
  reg [7:0]  next_rdata;             // read mux result
  reg        next_div_two;           // effective divisor
  reg [1:0]  next_drive;             // effective drive
  reg [1:0]  next_code;              // effective code

  // pattern activation pipeline
  reg [7:0]  stage_ctrl_a;           // first stage control
  reg [15:0] stage_one_a;            // first stage user word one
  reg [15:0] stage_two_a;            // first stage user word two
  reg [7:0]  stage_ctrl_b;           // second stage control
  reg [15:0] stage_one_b;            // second stage user word one
  reg [15:0] stage_two_b;            // second stage user word two
  reg        alt_phase;              // alternate word select
  reg        next_active;            // pattern enabled
  reg        next_alternate;         // two-word pattern
  reg [15:0] word_first;             // selected first word
  reg [15:0] word_second;            // selected second word

  wire [5:0] pins_synced;            // synchronised tri-level pins
  wire       write_hit;              // write strobe present
  wire [7:0] rate_decoded;           // decoded rate write

  assign write_hit = reg_write;

  // setting = written value xor prior raw and prior setting
  assign rate_decoded = reg_wdata ^ output_rate_control
                        ^ loop_range_state; // [R20] [R11]

  // tri-level pins pass two flops before use
  pin_sync #(
    .WIDTH (6)
  ) u_pin_sync (
    .clock   (clock),
    .nrst    (nrst),
    .pin_in  ({divisor_select_pin, output_drive_select_pin,
               output_code_select_pin}),
    .pin_out (pins_synced)
  );

  // registers that a soft reset returns to default
  always @(posedge clock) begin
    if (!nrst || soft_reset) begin
      core_skew_trim        <= `SKEW_RESET; // [R2] [R19]
      divided_clock_advance <= `ZERO_BYTE;  // [R19]
      output_rate_control   <= `ZERO_BYTE;
      loop_range_state      <= `ZERO_BYTE;  // fast range default [R9]
      pattern_test_control  <= `ZERO_BYTE;
      custom_word_one_low   <= `ZERO_BYTE;
      custom_word_one_high  <= `ZERO_BYTE;
      custom_word_two_low   <= `ZERO_BYTE;
      custom_word_two_high  <= `ZERO_BYTE;
    end else if (write_hit) begin
      case (reg_addr)
        `ADDR_SKEW:    core_skew_trim        <= reg_wdata; // [R1]
        `ADDR_ADVANCE: divided_clock_advance <= reg_wdata;
        `ADDR_RATE: begin
          output_rate_control <= reg_wdata;
          loop_range_state    <= rate_decoded; // [R20]
        end
        `ADDR_PATTERN: pattern_test_control <= reg_wdata;
        `ADDR_W1_LOW:  custom_word_one_low  <= reg_wdata; // [R17]
        `ADDR_W1_HIGH: custom_word_one_high <= reg_wdata; // [R17]
        `ADDR_W2_LOW:  custom_word_two_low  <= reg_wdata; // [R18]
        `ADDR_W2_HIGH: custom_word_two_high <= reg_wdata; // [R18]
        default: begin
          // other addresses, including the loop register, ignored
        end
      endcase
    end
  end

  // override registers survive a soft reset
  always @(posedge clock) begin
    if (!nrst) begin
      divisor_override       <= `ZERO_BYTE;
      output_format_override <= `ZERO_BYTE;
    end else if (write_hit && !soft_reset) begin
      if (reg_addr == `ADDR_DIVISOR)
        divisor_override <= reg_wdata;       // [R6]
      if (reg_addr == `ADDR_FORMAT)
        output_format_override <= reg_wdata; // [R6]
    end
  end

  // phase slip armed by a one written over a stored zero
  always @(posedge clock) begin
    if (!nrst || soft_reset) begin
      slip_request <= 1'b0;
    end else if (write_hit && reg_addr == `ADDR_ADVANCE
                 && reg_wdata[`ADVANCE_BIT]
                 && !divided_clock_advance[`ADVANCE_BIT]) begin
      slip_request <= div_by_two; // only meaningful in divide by two [R4]
    end else begin
      slip_request <= 1'b0;
    end
  end

  // effective divisor, drive and code from override or pins
  always @* begin
    // divisor: low pin divides by one, others by two
    case (divisor_override[2:0])
      `OVR_ONE: next_div_two = 1'b0; // [R5]
      `OVR_TWO: next_div_two = 1'b1; // [R5]
      default:  next_div_two = (pins_synced[5:4] != `PIN_LOW); // [R21]
    endcase
    // drive strength and physical format
    case (output_format_override[`DRIVE_HI:`DRIVE_LO])
      `OVR_ONE:  next_drive = `DRIVE_LVDS_2MA; // [R7]
      `OVR_TWO:  next_drive = `DRIVE_LVDS_3MA; // [R7]
      `OVR_FOUR: next_drive = `DRIVE_LVCMOS;   // [R7]
      default: begin
        if (pins_synced[3:2] == `PIN_HIGH)
          next_drive = `DRIVE_LVCMOS;          // [R21]
        else
          next_drive = pins_synced[3:2];       // [R21]
      end
    endcase
    // sample coding
    case (output_format_override[`CODE_HI:`CODE_LO])
      `OVR_ONE:  next_code = `CODE_TWOS;   // [R8]
      `OVR_TWO:  next_code = `CODE_GRAY;   // [R8]
      `OVR_FOUR: next_code = `CODE_OFFSET; // [R8]
      default: begin
        if (pins_synced[1:0] == `PIN_HIGH)
          next_code = `CODE_OFFSET;        // [R21]
        else
          next_code = pins_synced[1:0];    // [R21]
      end
    endcase
  end

  // divided clock phase, a slip skips one toggle
  always @(posedge clock) begin
    if (!nrst) begin
      div_by_two    <= 1'b0;
      divided_phase <= 1'b0;
    end else begin
      div_by_two <= next_div_two;
      if (!div_by_two)
        divided_phase <= 1'b0;
      else if (slip_request)
        divided_phase <= divided_phase; // edge moves one cycle [R3]
      else
        divided_phase <= ~divided_phase;
    end
  end

  // configuration outputs
  always @(posedge clock) begin
    if (!nrst) begin
      skew_trim   <= `SKEW_RESET;
      drive_mode  <= `DRIVE_LVDS_2MA;
      code_format <= `CODE_TWOS;
      ddr_enable  <= 1'b0;
      loop_slow   <= 1'b0;
    end else begin
      skew_trim   <= core_skew_trim;                    // [R1]
      drive_mode  <= next_drive;
      code_format <= next_code;
      ddr_enable  <= loop_range_state[`DDR_BIT];        // [R11]
      loop_slow   <= loop_range_state[`LOOP_SLOW_BIT];  // [R9]
    end
  end

  // read mux, unmapped addresses read zero
  always @* begin
    case (reg_addr)
      `ADDR_SKEW:    next_rdata = core_skew_trim;
      `ADDR_ADVANCE: next_rdata = divided_clock_advance;
      `ADDR_DIVISOR: next_rdata = divisor_override;
      `ADDR_FORMAT:  next_rdata = output_format_override;
      `ADDR_RATE:    next_rdata = output_rate_control;
      `ADDR_LOOP:    next_rdata = loop_range_state; // [R9]
      `ADDR_PATTERN: next_rdata = pattern_test_control;
      `ADDR_W1_LOW:  next_rdata = custom_word_one_low;
      `ADDR_W1_HIGH: next_rdata = custom_word_one_high;
      `ADDR_W2_LOW:  next_rdata = custom_word_two_low;
      `ADDR_W2_HIGH: next_rdata = custom_word_two_high;
      default:       next_rdata = `ZERO_BYTE;
    endcase
  end

  // read data registered one cycle after the strobe
  always @(posedge clock) begin
    if (!nrst) begin
      reg_rdata  <= `ZERO_BYTE;
      read_valid <= 1'b0;
    end else begin
      read_valid <= reg_read;
      if (reg_read)
        reg_rdata <= next_rdata;
    end
  end

  // pattern settings pass two stages before the outputs
  always @(posedge clock) begin
    if (!nrst) begin
      stage_ctrl_a <= `ZERO_BYTE;
      stage_one_a  <= `WORD_ZEROS;
      stage_two_a  <= `WORD_ZEROS;
      stage_ctrl_b <= `ZERO_BYTE;
      stage_one_b  <= `WORD_ZEROS;
      stage_two_b  <= `WORD_ZEROS;
    end else begin
      stage_ctrl_a <= pattern_test_control;                        // [R15]
      stage_one_a  <= {custom_word_one_high, custom_word_one_low}; // [R17]
      stage_two_a  <= {custom_word_two_high, custom_word_two_low}; // [R18]
      stage_ctrl_b <= stage_ctrl_a;                                // [R15]
      stage_one_b  <= stage_one_a;
      stage_two_b  <= stage_two_a;
    end
  end

  // pattern word decode
  always @*
  begin
    word_first     = `WORD_ZEROS;
    word_second    = `WORD_ZEROS;
    next_active    = 1'b1;
    next_alternate = 1'b0;
    case (stage_ctrl_b[`SEL_HI:`SEL_LO])
      `SEL_MID:   word_first = `WORD_MID;   // [R16]
      `SEL_PLUS:  word_first = `WORD_ONES;  // [R16]
      `SEL_MINUS: word_first = `WORD_ZEROS; // [R16]
      `SEL_CHECKER: begin
        word_first     = `WORD_CHECK_A;     // [R16]
        word_second    = `WORD_CHECK_B;
        next_alternate = 1'b1;
      end
      `SEL_ONE_ZERO: begin
        word_first     = `WORD_ONES;        // [R16]
        word_second    = `WORD_ZEROS;
        next_alternate = 1'b1;
      end
      `SEL_USER: begin
        word_first     = stage_one_b;       // [R16] [R17]
        word_second    = stage_two_b;       // [R18]
        next_alternate = 1'b1;
      end
      default: next_active = 1'b0;          // off and reserved codes
    endcase
    // reserved mode values disable the pattern
    case (stage_ctrl_b[`MODE_HI:`MODE_LO])
      `MODE_STATIC:    next_alternate = 1'b0; // [R13]
      `MODE_ALTERNATE: next_alternate = next_alternate; // [R13]
      default: begin
        next_active    = 1'b0;                // [R13]
        next_alternate = 1'b0;
      end
    endcase
  end

  // test word output, alternating per clock when asked
  always @(posedge clock) begin
    if (!nrst) begin
      test_active <= 1'b0;
      test_word   <= `WORD_ZEROS;
      alt_phase   <= 1'b0;
    end else begin
      test_active <= next_active;
      if (next_active && next_alternate)
        alt_phase <= ~alt_phase;     // [R14]
      else
        alt_phase <= 1'b0;
      if (!next_active)
        test_word <= `WORD_ZEROS;
      else if (next_alternate && alt_phase)
        test_word <= word_second;    // [R14]
      else
        test_word <= word_first;     // static holds one word [R14]
    end
  end

endmodule // adc_global_config_test_regs

// file: rtl/adc_global_defs.vh
// constants for the global configuration and test register group
// assumes 13-bit register addresses and 8-bit register data
`ifndef ADC_GLOBAL_DEFS_VH
`define ADC_GLOBAL_DEFS_VH

// register addresses
`define ADDR_SKEW        13'h0070
`define ADDR_ADVANCE     13'h0071
`define ADDR_DIVISOR     13'h0072
`define ADDR_FORMAT      13'h0073
`define ADDR_RATE        13'h0074
`define ADDR_LOOP        13'h0075
`define ADDR_PATTERN     13'h00c0
`define ADDR_W1_LOW      13'h00c2
`define ADDR_W1_HIGH     13'h00c3
`define ADDR_W2_LOW      13'h00c4
`define ADDR_W2_HIGH     13'h00c5

// reset values
`define SKEW_RESET       8'h80
`define ZERO_BYTE        8'h00

// field positions
`define ADVANCE_BIT      0
`define LOOP_SLOW_BIT    6
`define DDR_BIT          0
`define DRIVE_HI         7
`define DRIVE_LO         5
`define CODE_HI          2
`define CODE_LO          0
`define MODE_HI          7
`define MODE_LO          6
`define SEL_HI           3
`define SEL_LO           0

// three-bit override codes
`define OVR_PIN          3'h0
`define OVR_ONE          3'h1
`define OVR_TWO          3'h2
`define OVR_FOUR         3'h4

// tri-level pin codes after sampling
`define PIN_LOW          2'h0
`define PIN_MID          2'h1
`define PIN_HIGH         2'h2

// effective drive and code selections
`define DRIVE_LVDS_2MA   2'h0
`define DRIVE_LVDS_3MA   2'h1
`define DRIVE_LVCMOS     2'h2
`define CODE_TWOS        2'h0
`define CODE_GRAY        2'h1
`define CODE_OFFSET      2'h2

// pattern modes and selectors
`define MODE_STATIC      2'h0
`define MODE_ALTERNATE   2'h1
`define SEL_OFF          4'h0
`define SEL_MID          4'h1
`define SEL_PLUS         4'h2
`define SEL_MINUS        4'h3
`define SEL_CHECKER      4'h4
`define SEL_ONE_ZERO     4'h7
`define SEL_USER         4'h8

// preset words
`define WORD_MID         16'h8000
`define WORD_ONES        16'hffff
`define WORD_ZEROS       16'h0000
`define WORD_CHECK_A     16'haaaa
`define WORD_CHECK_B     16'h5555

`endif

// file: rtl/pin_sync.v
// two-flop synchroniser for a group of asynchronous pin levels
// assumes the pins are quasi-static straps; bits are not aligned
`timescale 1ns/1ps

module pin_sync #(
  parameter WIDTH = 6                  // number of pin bits
) (
  input  wire             clock,       // block clock
  input  wire             nrst,        // synchronous reset, active low
  input  wire [WIDTH-1:0] pin_in,      // raw pin levels
  output reg  [WIDTH-1:0] pin_out      // synchronised levels
);

  reg [WIDTH-1:0] first;               // metastability stage, read below only

  // two stages, the first read by the second alone
  always @(posedge clock) begin
    if (!nrst) begin
      first   <= {WIDTH{1'b0}};
      pin_out <= {WIDTH{1'b0}};
    end else begin
      first   <= pin_in;
      pin_out <= first;
    end
  end

endmodule // pin_sync

// file: test/adc_global_checker.sv
// assertions on the register group ports
// assumes a bind onto the register group top, one clock domain
`timescale 1ns/1ps
`include "adc_global_defs.vh"

module adc_global_checker (
  input wire        clock,
  input wire        nrst,
  input wire        reg_write,
  input wire        reg_read,
  input wire [12:0] reg_addr,
  input wire [7:0]  reg_wdata,
  input wire        soft_reset,
  input wire [7:0]  reg_rdata,
  input wire        read_valid,
  input wire [7:0]  skew_trim,
  input wire        div_by_two,
  input wire        divided_phase,
  input wire [1:0]  drive_mode,
  input wire [1:0]  code_format,
  input wire        test_active,
  input wire [15:0] test_word
);
  // a write not lost to a soft reset
  wire wr     = reg_write && !soft_reset;
  wire wr_fmt = wr && reg_addr == `ADDR_FORMAT;  // format override write
  wire wr_pat = wr && reg_addr == `ADDR_PATTERN; // pattern control write

  default clocking dc @(posedge clock); endclocking
  default disable iff (!nrst);

  property p_skew_follow;
    wr && reg_addr == `ADDR_SKEW |-> ##2 skew_trim == $past(reg_wdata, 2);
  endproperty
  a_skew_follow: assert property (p_skew_follow)
    else $error("skew not following write");
  property p_read_skew;
    reg_read && reg_addr == `ADDR_SKEW |=> read_valid && reg_rdata == skew_trim;
  endproperty
  a_read_skew: assert property (p_read_skew)
    else $error("skew read mismatch");
  property p_skew_reset;
    $rose(nrst) |-> skew_trim == `SKEW_RESET;
  endproperty
  a_skew_reset: assert property (p_skew_reset)
    else $error("skew reset value wrong");
  property p_soft_skew;
    soft_reset |-> ##2 skew_trim == `SKEW_RESET;
  endproperty
  a_soft_skew: assert property (p_soft_skew)
    else $error("skew not soft reset");
  property p_phase_idle;
    !div_by_two ##1 !div_by_two |-> !divided_phase;
  endproperty
  a_phase_idle: assert property (p_phase_idle)
    else $error("phase moves undivided");
  property p_divisor;
    wr && reg_addr == `ADDR_DIVISOR && reg_wdata[2:0] inside {3'h1, 3'h2}
      |-> ##2 div_by_two == $past(reg_wdata[1], 2);
  endproperty
  a_divisor: assert property (p_divisor)
    else $error("divisor not overridden");
  property p_drive;
    wr_fmt && reg_wdata[7:5] == `OVR_FOUR |-> ##2 drive_mode == `DRIVE_LVCMOS;
  endproperty
  a_drive: assert property (p_drive)
    else $error("drive not overridden");
  property p_code;
    wr_fmt && reg_wdata[2:0] == `OVR_TWO |-> ##2 code_format == `CODE_GRAY;
  endproperty
  a_code: assert property (p_code)
    else $error("code not overridden");
  property p_mode_reserved;
    wr_pat && reg_wdata[7] ##1 (!wr_pat && !soft_reset) [*3]
      |-> ##1 !test_active && test_word == `WORD_ZEROS;
  endproperty
  a_mode_reserved: assert property (p_mode_reserved)
    else $error("reserved mode drives word");
  property p_off_zero;
    !test_active |-> test_word == `WORD_ZEROS;
  endproperty
  a_off_zero: assert property (p_off_zero)
    else $error("word not zero when off");
endmodule // adc_global_checker

// file: test/host_model.sv
// host model driving the register strobes
// assumes one strobe per request and the read answer one cycle later
`timescale 1ns/1ps
`include "adc_global_defs.vh"

module host_model (
  input  wire         clock,      // block clock
  input  wire  [7:0]  reg_rdata,  // read data from the block
  input  wire         read_valid, // read answer strobe
  output logic        reg_write,  // write strobe
  output logic        reg_read,   // read strobe
  output logic [12:0] reg_addr,   // register address
  output logic [7:0]  reg_wdata,  // write data
  output logic        soft_reset  // soft reset pulse
);
  // idle bus from time zero
  initial begin
    reg_write = 1'b0;
    reg_read = 1'b0;
    reg_addr = 13'h0000;
    reg_wdata = 8'h00;
    soft_reset = 1'b0;
  end
  // one write, idle lines show the inverse
  task wr(input logic [12:0] a, input logic [7:0] x);
    @(posedge clock);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= x;
    @(posedge clock);
    reg_write <= 1'b0;
    reg_addr <= ~a;
    reg_wdata <= ~x;
  endtask
  // one read, answer taken after the edge
  task rd(input logic [12:0] a, output logic [7:0] x, output logic ok);
    @(posedge clock);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_read <= 1'b0;
    reg_addr <= ~a;
    #1 ok = read_valid;
    x = reg_rdata;
  endtask
  // soft reset pulse
  task srst;
    @(posedge clock);
    soft_reset <= 1'b1;
    @(posedge clock);
    soft_reset <= 1'b0;
  endtask
  // phase slip: bit zero cleared, then set
  task slip;
    wr(`ADDR_ADVANCE, 8'h00);
    wr(`ADDR_ADVANCE, 8'h01);
  endtask
  // ddr and loop range: caller picks a range for its sample rate
  task set_rate(input logic [7:0] want);
    logic [7:0] r74, r75;
    logic       ok;
    rd(`ADDR_RATE, r74, ok);
    rd(`ADDR_LOOP, r75, ok);
    wr(`ADDR_RATE, want ^ r74 ^ r75);
  endtask
endmodule // host_model

// file: test/tb_top.sv
// self-checking bench for the global configuration and test registers
// assumes the host model owns the bus and the bench owns the pins
`timescale 1ns/1ps
`include "adc_global_defs.vh"

module tb_top;
  logic        clock, nrst;                 // clock and reset
  logic [1:0]  div_pin, drv_pin, cod_pin;   // tri-level pin codes
  logic        reg_write, reg_read, soft_reset, read_valid, v; // strobes
  logic [12:0] reg_addr;                    // register address
  logic [7:0]  reg_wdata, reg_rdata, skew_trim, d; // bus and skew
  logic        div_by_two, divided_phase, ddr_enable, loop_slow; // clocking
  logic        test_active;                 // pattern on
  logic [1:0]  drive_mode, code_format;     // effective format
  logic [15:0] test_word, w0, w1;           // pattern words
  int          err_total, tests_run, same;  // counters
  int          cycles = 0;                  // timeout counter
  localparam logic [12:0] reg_list [12] = '{`ADDR_SKEW, `ADDR_ADVANCE,
    `ADDR_DIVISOR, `ADDR_FORMAT, `ADDR_RATE, `ADDR_LOOP, `ADDR_PATTERN,
    `ADDR_W1_LOW, `ADDR_W1_HIGH, `ADDR_W2_LOW, `ADDR_W2_HIGH, 13'h0076};
  localparam logic [2:0]  ovr [4] = '{3'h2, 3'h4, 3'h1, 3'h0}; // codes
  localparam logic [1:0]  div_x [4] = '{2'h1, 2'h0, 2'h0, 2'h0};
  localparam logic [1:0]  drv_x [4] = '{2'h1, 2'h2, 2'h0, 2'h2};
  localparam logic [1:0]  cod_x [4] = '{2'h1, 2'h2, 2'h0, 2'h1};
  localparam logic [15:0] w1_tab [9] = '{16'h0000, 16'h8000, 16'hffff,
    16'h0000, 16'haaaa, 16'h0000, 16'h0000, 16'hffff, 16'h1234};
  localparam logic [15:0] w2_tab [9] = '{16'h0000, 16'h8000, 16'hffff,
    16'h0000, 16'h5555, 16'h0000, 16'h0000, 16'h0000, 16'habcd};
  localparam logic [8:0]  act_tab = 9'h19e; // selectors that drive a word

  adc_global_config_test_regs u_adc_global_config_test_regs (
    .clock(clock), .nrst(nrst), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .soft_reset(soft_reset),
    .divisor_select_pin(div_pin), .output_drive_select_pin(drv_pin),
    .output_code_select_pin(cod_pin), .reg_rdata(reg_rdata),
    .read_valid(read_valid), .skew_trim(skew_trim), .div_by_two(div_by_two),
    .divided_phase(divided_phase), .drive_mode(drive_mode),
    .code_format(code_format), .ddr_enable(ddr_enable),
    .loop_slow(loop_slow), .test_active(test_active), .test_word(test_word));
  host_model u_host_model (.clock(clock), .reg_rdata(reg_rdata),
    .read_valid(read_valid), .reg_write(reg_write), .reg_read(reg_read),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .soft_reset(soft_reset));

  // compare and count
  task check(input string name, input logic [15:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // counts and verdict
  task finish_test;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // reset values, and an unmapped read
  task t_reset;
    for (int i = 0; i < 12; i++) begin
      u_host_model.rd(reg_list[i], d, v);
      check("reset value", {v, d}, {1'b1, i == 0 ? 8'h80 : 8'h00});
    end
  endtask
  // skew trim at both ends of its range
  task t_skew;
    for (int i = 0; i < 2; i++) begin
      u_host_model.wr(`ADDR_SKEW, i ? 8'h00 : 8'hff);
      u_host_model.rd(`ADDR_SKEW, d, v);
      check("skew", {d, skew_trim}, i ? 16'h0000 : 16'hffff);
    end
  endtask
  // override codes, forbidden code, pin control
  task t_codes;
    for (int i = 0; i < 4; i++) begin
      u_host_model.wr(`ADDR_DIVISOR, {5'h00, ovr[i]});
      u_host_model.wr(`ADDR_FORMAT, {ovr[i], 2'b00, ovr[i]});
      repeat (3) @(posedge clock);
      check("divisor", div_by_two, div_x[i]);
      check("drive", drive_mode, drv_x[i]);
      check("code", code_format, cod_x[i]);
    end
    @(posedge clock) div_pin <= 2'h1;
    repeat (6) @(posedge clock);
    check("divisor pin", div_by_two, 1'b1);
  endtask
  // soft reset keeps divisor and format, restores skew and first user word low
  task t_soft;
    u_host_model.wr(`ADDR_DIVISOR, 8'h01);
    u_host_model.wr(`ADDR_FORMAT, 8'h21);
    u_host_model.wr(`ADDR_SKEW, 8'h11);
    u_host_model.wr(`ADDR_W1_LOW, 8'h55);
    u_host_model.srst;
    for (int i = 0; i < 4; i++) begin
      u_host_model.rd(reg_list[i == 1 ? 7 : i == 0 ? 0 : i], d, v);
      check("soft reset", d, i == 0 ? 8'h80 : i == 3 ? 8'h21 : {7'h0, i[1]});
    end
    check("soft keeps", {div_by_two, drive_mode, code_format}, 5'h00);
  endtask
  // held cycles of divided phase over six edges
  task count_same;
    logic p;
    same = 0;
    #1 p = divided_phase;
    repeat (6) begin
      @(posedge clock);
      #1 same += int'(divided_phase === p);
      p = divided_phase;
    end
  endtask
  // phase slip in divide by two, repeated set ignored
  task t_slip;
    u_host_model.wr(`ADDR_DIVISOR, 8'h02);
    repeat (4) @(posedge clock);
    u_host_model.slip;
    count_same;
    check("slip once", same, 1);
    u_host_model.wr(`ADDR_ADVANCE, 8'h01);
    count_same;
    check("no slip", same, 0);
  endtask
  // ddr and loop range through the folded write
  task t_rate;
    for (int i = 0; i < 4; i++) begin
      u_host_model.set_rate(8'h41 >> i);
      u_host_model.rd(`ADDR_LOOP, d, v);
      check("rate state", d, 8'h41 >> i);
      check("rate outs", {loop_slow, ddr_enable}, {2{i == 0}});
    end
  endtask
  // one pattern, two words in either order
  task pat(input logic [7:0] ctl, input logic [15:0] a, b, input logic on);
    u_host_model.wr(`ADDR_PATTERN, ctl);
    repeat (3) @(posedge clock);
    #1 w0 = test_word;
    @(posedge clock);
    #1 w1 = test_word;
    check("word low", w0 < w1 ? w0 : w1, a < b ? a : b);
    check("word high", w0 < w1 ? w1 : w0, a < b ? b : a);
    check("pattern on", test_active, on);
  endtask
  // all selectors in alternate mode, then static and reserved modes
  task t_pat;
    u_host_model.wr(`ADDR_W1_LOW, 8'h34);
    u_host_model.wr(`ADDR_W1_HIGH, 8'h12);
    u_host_model.wr(`ADDR_W2_LOW, 8'hcd);
    u_host_model.wr(`ADDR_W2_HIGH, 8'hab);
    for (int i = 0; i < 9; i++)
      pat(8'h40 | i[7:0], w1_tab[i], w2_tab[i], act_tab[i]);
    pat(8'h04, 16'haaaa, 16'haaaa, 1'b1);
    pat(8'h08, 16'h1234, 16'h1234, 1'b1);
    pat(8'h88, 16'h0000, 16'h0000, 1'b0);
    pat(8'hc7, 16'h0000, 16'h0000, 1'b0);
  endtask

  // clock, 100 ns period
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 4000) begin
      err_total++;
      finish_test;
    end
  end
  // main sequence
  initial begin
    nrst = 1'b0;
    div_pin = 2'h0;
    drv_pin = 2'h2;
    cod_pin = 2'h1;
    err_total = 0;
    tests_run = 0;
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    t_reset;
    t_skew;
    t_codes;
    t_soft;
    t_slip;
    t_rate;
    t_pat;
    finish_test;
  end
endmodule // tb_top

bind adc_global_config_test_regs adc_global_checker u_adc_global_checker (
  .clock(clock), .nrst(nrst), .reg_write(reg_write), .reg_read(reg_read),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .soft_reset(soft_reset),
  .reg_rdata(reg_rdata), .read_valid(read_valid), .skew_trim(skew_trim),
  .div_by_two(div_by_two), .divided_phase(divided_phase),
  .drive_mode(drive_mode), .code_format(code_format),
  .test_active(test_active), .test_word(test_word));
